// ==== flip_flop_cell_pkg.sv ====
package flip_flop_cell_pkg;

  // ----------------------------------------
  // Output pair carried by every cell
  // ----------------------------------------
  typedef struct packed {
    logic true_output; // Stored bit as seen outside
    logic complement_output; // Normally its inverse
  } pair_type;

  // Fixed output codes (true bit is the upper bit)
  localparam pair_type PAIR_CLEAR = 2'h1; // 0 and 1
  localparam pair_type PAIR_SET = 2'h2; // 1 and 0
  localparam pair_type PAIR_BOTH = 2'h3; // 1 and 1, double force

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_MHZ = 250; // System clock rate
  localparam int PULSE_TIME_US_DEFAULT = 10000; // 10 ms
  localparam int PULSE_TIME_US_MIN = 1; // 0.001 ms
  localparam int PULSE_TIME_US_MAX = 10000000; // 10000 ms
  localparam int PULSE_COUNT_WIDTH = 32; // Holds 2.5e9 cycles
  localparam int PULSE_LAST_OFFSET = 1; // Count runs to zero

  // ----------------------------------------
  // Monoflop states, one-hot
  // ----------------------------------------
  typedef enum logic [1:0] {
    MONO_IDLE = 2'h1,
    MONO_PULSE = 2'h2
  } mono_state_type;

  // ----------------------------------------
  // Raw cell inputs, as driven by neighbours
  // ----------------------------------------
  typedef struct packed {
    logic latch_strobe;
    logic latch_data;
    logic dff_strobe;
    logic dff_data;
    logic dffc_strobe;
    logic dffc_data;
    logic dffc_force_low; // Active high
    logic dffsc_strobe;
    logic dffsc_data;
    logic dffsc_force_low_n; // Active low
    logic dffsc_force_high; // Active high
    logic dffn_strobe;
    logic dffn_data;
    logic dffn_force_high_n; // Active low
    logic dffn_force_low_n; // Active low
    logic tff_toggle;
    logic tffr_toggle;
    logic tffr_force_low; // Active high
    logic tffrn_toggle;
    logic tffrn_force_low_n; // Active low
    logic tffsn_toggle;
    logic tffsn_force_high_n; // Active low
    logic rise_trigger;
    logic fall_trigger;
  } cell_in_type;

  // ----------------------------------------
  // Cell outputs
  // ----------------------------------------
  typedef struct packed {
    pair_type latch;
    pair_type dff;
    pair_type dffc;
    pair_type dffsc;
    pair_type dffn;
    pair_type tff;
    pair_type tffr;
    pair_type tffrn;
    pair_type tffsn;
    pair_type rise_mono;
    pair_type fall_mono;
  } cell_out_type;

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  // Pair with a true bit and its exact inverse
  function automatic pair_type pair_of(input logic value);
    pair_type result;
    result.true_output = value;
    result.complement_output = ~value;
    return result;
  endfunction

  // Low-to-high between two samples
  function automatic logic rising(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  // High-to-low between two samples
  function automatic logic falling(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  // Swap of both outputs, keeps them complementary
  function automatic pair_type toggled(input pair_type cur);
    return pair_of(~cur.true_output);
  endfunction

endpackage

// ==== edge_monoflop.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// One-shot pulse on a chosen trigger edge
// ----------------------------------------
module edge_monoflop #(
  parameter int PULSE_TIME_US = flip_flop_cell_pkg::PULSE_TIME_US_DEFAULT,
  parameter bit RISING = 1'b1, // Edge polarity
  parameter bit RETRIGGER = 1'b0, // Restart on new edge
  parameter int COUNT_WIDTH = flip_flop_cell_pkg::PULSE_COUNT_WIDTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic trigger, // Already synchronised
  output flip_flop_cell_pkg::pair_type pulse
);
  import flip_flop_cell_pkg::*;

  // Pulse length in clock periods; whole microseconds are exact
  localparam longint CYCLES_WIDE = longint'(PULSE_TIME_US) * CLOCK_MHZ;
  localparam logic [COUNT_WIDTH-1:0] PULSE_CYCLES =
    COUNT_WIDTH'(CYCLES_WIDE);
  localparam logic [COUNT_WIDTH-1:0] LOAD_VALUE =
    PULSE_CYCLES - COUNT_WIDTH'(PULSE_LAST_OFFSET);
  localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = '0;

  typedef struct packed {
    mono_state_type state; // Idle or pulsing
    logic prev; // Trigger one cycle ago
    logic [COUNT_WIDTH-1:0] count; // Cycles left minus one
    pair_type out; // Registered output pair
  } mono_type;

  mono_type cur; // Registered state
  mono_type next_cur; // Next state
  logic hit; // Qualifying edge this cycle

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.prev = trigger;
    // Edge polarity fixed per instance
    hit = RISING ? rising(cur.prev, trigger)
      : falling(cur.prev, trigger);
    case (cur.state)
      MONO_IDLE: begin
        if (hit) begin
          next_cur.state = MONO_PULSE;
          next_cur.count = LOAD_VALUE;
        end
      end
      MONO_PULSE: begin
        if (hit && RETRIGGER) begin
          next_cur.count = LOAD_VALUE;
        end else if (cur.count == COUNT_ZERO) begin
          next_cur.state = MONO_IDLE;
        end else begin
          // Edges without retrigger are ignored here
          next_cur.count = cur.count
            - COUNT_WIDTH'(PULSE_LAST_OFFSET);
        end
      end
      default: begin
        next_cur.state = MONO_IDLE;
      end
    endcase
    // Complement always follows the true bit
    next_cur.out = pair_of(next_cur.state == MONO_PULSE);
  end

  // ----------------------------------------
  // State register, synchronous reset
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cur <= '{state: MONO_IDLE, prev: 1'b0, count: COUNT_ZERO,
               out: PAIR_CLEAR};
    end else begin
      cur <= next_cur;
    end
  end

  assign pulse = cur.out;

endmodule

// ==== flip_flop_cell_set.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// - Latch follows data while strobe high
// - Latch holds both outputs while strobe low
// - Data cell captures only on rising strobe
// - Active-high clear forces 0 and 1
// - Active-low clear forces 0 and 1
// - Set forces 1; both forces give 1,1
// - Two low forces: set, clear, or 1,1
// - Toggle cell swaps outputs on rising edge
// - Toggle outputs always stay complementary
// - Active-high force-low holds toggle cell clear
// - Low force-low input clears toggle cell
// - Low force-high input sets toggle cell
// - Rising trigger starts a timed high pulse
// - Falling trigger starts a timed high pulse
// - Retrigger option restarts pulse; default off
// - Pulse time 0.001 to 10000 ms, default 10
// - Monoflop complement is inverse of true output

module flip_flop_cell_set #(
  // Pulse times in microseconds, range 1 to 10000000
  parameter int RISE_PULSE_TIME_US =
    flip_flop_cell_pkg::PULSE_TIME_US_DEFAULT,
  parameter int FALL_PULSE_TIME_US =
    flip_flop_cell_pkg::PULSE_TIME_US_DEFAULT,
  parameter bit RISE_RETRIGGER = 1'b0, // Off by default
  parameter bit FALL_RETRIGGER = 1'b0 // Off by default
) (
  input wire logic clock,
  input wire logic rst_n,
  input flip_flop_cell_pkg::cell_in_type cells_in,
  output flip_flop_cell_pkg::cell_out_type cells_out
);
  import flip_flop_cell_pkg::*;

  // ----------------------------------------
  // State of all storage cells but the monoflops
  // ----------------------------------------
  typedef struct packed {
    cell_in_type meta; // First synchroniser stage
    cell_in_type sync; // Second stage, safe to read
    cell_in_type prev; // Second stage delayed, for edges
    pair_type latch; // Level latch
    pair_type dff; // Plain edge cell
    pair_type dffc; // Edge cell with clear
    pair_type dffsc; // Edge cell with set and clear
    pair_type dffn; // Edge cell with low forces
    pair_type tff; // Plain toggle
    pair_type tffr; // Toggle, high force-low
    pair_type tffrn; // Toggle, low force-low
    pair_type tffsn; // Toggle, low force-high
  } cells_type;

  cells_type cur; // Registered state
  cells_type next_cur; // Next state

  // Inputs at rest: active-low forces released. Resetting the
  // stages to this keeps release from acting as a force.
  localparam cell_in_type CELLS_IDLE = '{
    dffsc_force_low_n: 1'b1,
    dffn_force_high_n: 1'b1,
    dffn_force_low_n: 1'b1,
    tffrn_force_low_n: 1'b1,
    tffsn_force_high_n: 1'b1,
    default: 1'b0
  };

  // Monoflop outputs, registered inside the leaf
  pair_type rise_pulse;
  pair_type fall_pulse;

  // ----------------------------------------
  // Local helpers
  // ----------------------------------------
  // Edge cell without forces: capture on edge else hold
  function automatic pair_type edge_capture(
    input pair_type held,
    input logic strobe_prev,
    input logic strobe,
    input logic data
  );
    pair_type result;
    result = held;
    if (rising(strobe_prev, strobe)) begin
      result = pair_of(data);
    end
    return result;
  endfunction

  // Toggle cell without forces: swap on edge else hold
  function automatic pair_type edge_toggle(
    input pair_type held,
    input logic toggle_prev,
    input logic toggle
  );
    pair_type result;
    result = held;
    if (rising(toggle_prev, toggle)) begin
      result = toggled(held);
    end
    return result;
  endfunction

  // Two-force priority shared by both force cells
  function automatic pair_type forced_pair(
    input logic want_high,
    input logic want_low,
    input pair_type normal
  );
    pair_type result;
    if (want_high && want_low) begin
      result = PAIR_BOTH;
    end else if (want_high) begin
      result = PAIR_SET;
    end else if (want_low) begin
      result = PAIR_CLEAR;
    end else begin
      result = normal;
    end
    return result;
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Every cell input comes from outside this clock, so all of
  // them pass two flops; cost is two cycles of latency per cell.
  always_comb begin
    next_cur = cur;
    next_cur.meta = cells_in;
    next_cur.sync = cur.meta; // Only reader of meta
    next_cur.prev = cur.sync; // Edge reference

    // ----------------------------------------
    // Level-sensitive latch
    // ----------------------------------------
    if (cur.sync.latch_strobe) begin
      // Transparent: output tracks data
      next_cur.latch = pair_of(cur.sync.latch_data);
    end else begin
      // Opaque: data ignored, both outputs kept
      next_cur.latch = cur.latch;
    end

    // ----------------------------------------
    // Plain edge-triggered data cell
    // ----------------------------------------
    // No forces: only a strobe edge moves it
    next_cur.dff = edge_capture(cur.dff, cur.prev.dff_strobe,
      cur.sync.dff_strobe, cur.sync.dff_data);

    // ----------------------------------------
    // Data cell with active-high clear
    // ----------------------------------------
    if (cur.sync.dffc_force_low) begin
      // Clear beats strobe and data
      next_cur.dffc = PAIR_CLEAR;
    end else begin
      next_cur.dffc = edge_capture(cur.dffc, cur.prev.dffc_strobe,
        cur.sync.dffc_strobe, cur.sync.dffc_data);
    end

    // ----------------------------------------
    // Data cell with high set and low clear
    // ----------------------------------------
    // Holding restores the complement, so a released double
    // force leaves a proper pair rather than 1,1.
    next_cur.dffsc = forced_pair(
      cur.sync.dffsc_force_high,
      ~cur.sync.dffsc_force_low_n,
      edge_capture(pair_of(cur.dffsc.true_output),
        cur.prev.dffsc_strobe, cur.sync.dffsc_strobe,
        cur.sync.dffsc_data));

    // ----------------------------------------
    // Data cell with two active-low forces
    // ----------------------------------------
    // Same priority helper as the cell above
    next_cur.dffn = forced_pair(
      ~cur.sync.dffn_force_high_n,
      ~cur.sync.dffn_force_low_n,
      edge_capture(pair_of(cur.dffn.true_output),
        cur.prev.dffn_strobe, cur.sync.dffn_strobe,
        cur.sync.dffn_data));

    // ----------------------------------------
    // Plain toggle cell
    // ----------------------------------------
    // Stored as a pair but always rebuilt from the true bit,
    // so the two outputs can never agree.
    next_cur.tff = edge_toggle(pair_of(cur.tff.true_output),
      cur.prev.tff_toggle, cur.sync.tff_toggle);

    // ----------------------------------------
    // Toggle cell, active-high force-low
    // ----------------------------------------
    if (cur.sync.tffr_force_low) begin
      // Held clear for as long as the force stands
      next_cur.tffr = PAIR_CLEAR;
    end else begin
      next_cur.tffr = edge_toggle(pair_of(cur.tffr.true_output),
        cur.prev.tffr_toggle, cur.sync.tffr_toggle);
    end

    // ----------------------------------------
    // Toggle cell, active-low force-low
    // ----------------------------------------
    // Force level first, edge second
    if (!cur.sync.tffrn_force_low_n) begin
      next_cur.tffrn = PAIR_CLEAR;
    end else begin
      next_cur.tffrn = edge_toggle(pair_of(cur.tffrn.true_output),
        cur.prev.tffrn_toggle, cur.sync.tffrn_toggle);
    end

    // ----------------------------------------
    // Toggle cell, active-low force-high
    // ----------------------------------------
    // An edge under force is lost
    if (!cur.sync.tffsn_force_high_n) begin
      next_cur.tffsn = PAIR_SET;
    end else begin
      next_cur.tffsn = edge_toggle(pair_of(cur.tffsn.true_output),
        cur.prev.tffsn_toggle, cur.sync.tffsn_toggle);
    end
  end

  // ----------------------------------------
  // State register, synchronous reset
  // ----------------------------------------
  // Toggle cells power up in an arbitrary state in the modelled
  // part; here reset picks the cleared pair so tests can rely on it.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      // Stages rest at idle levels
      cur.meta <= CELLS_IDLE;
      cur.sync <= CELLS_IDLE;
      cur.prev <= CELLS_IDLE;
      cur.latch <= PAIR_CLEAR;
      cur.dff <= PAIR_CLEAR;
      cur.dffc <= PAIR_CLEAR;
      cur.dffsc <= PAIR_CLEAR;
      cur.dffn <= PAIR_CLEAR;
      cur.tff <= PAIR_CLEAR;
      cur.tffr <= PAIR_CLEAR;
      cur.tffrn <= PAIR_CLEAR;
      cur.tffsn <= PAIR_CLEAR;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------
  // Monoflops
  // ----------------------------------------
  // Triggers are fed from the second synchroniser stage, so the
  // pulse starts with the same latency as the other cells.
  // Each leaf keeps its own edge reference and counter.
  edge_monoflop #(
    .PULSE_TIME_US(RISE_PULSE_TIME_US),
    .RISING(1'b1),
    .RETRIGGER(RISE_RETRIGGER),
    .COUNT_WIDTH(PULSE_COUNT_WIDTH)
  ) rise_mono (
    .clock(clock),
    .rst_n(rst_n),
    .trigger(cur.sync.rise_trigger),
    .pulse(rise_pulse)
  );

  edge_monoflop #(
    .PULSE_TIME_US(FALL_PULSE_TIME_US),
    .RISING(1'b0),
    .RETRIGGER(FALL_RETRIGGER),
    .COUNT_WIDTH(PULSE_COUNT_WIDTH)
  ) fall_mono (
    .clock(clock),
    .rst_n(rst_n),
    .trigger(cur.sync.fall_trigger),
    .pulse(fall_pulse)
  );

  // ----------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------
  // Plain wiring, no logic on the way out
  always_comb begin
    cells_out.latch = cur.latch;
    cells_out.dff = cur.dff;
    cells_out.dffc = cur.dffc;
    cells_out.dffsc = cur.dffsc;
    cells_out.dffn = cur.dffn;
    cells_out.tff = cur.tff;
    cells_out.tffr = cur.tffr;
    cells_out.tffrn = cur.tffrn;
    cells_out.tffsn = cur.tffsn;
    cells_out.rise_mono = rise_pulse;
    cells_out.fall_mono = fall_pulse;
  end

endmodule

// ==== flip_flop_cell_checker.sv ====
`timescale 1ns/1ps
// ------
// Port checker for the cell set
// ------
module flip_flop_cell_checker #(
  parameter int RISE_PULSE_TIME_US = 1,
  parameter int FALL_PULSE_TIME_US = 1,
  parameter bit RISE_RETRIGGER = 1'b0,
  parameter bit FALL_RETRIGGER = 1'b0
) (
  input wire logic clock,
  input wire logic rst_n,
  input flip_flop_cell_pkg::cell_in_type cells_in,
  input flip_flop_cell_pkg::cell_out_type cells_out
);
  import flip_flop_cell_pkg::*;
  localparam int FALL_CYCLES = FALL_PULSE_TIME_US * CLOCK_MHZ;
  logic [1:0] live; // Edges since release, stops at 3
  int fall_len; // High run of the falling pulse
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Synchronisers restart at idle levels, so edge checks wait for live
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      live <= 2'h0;
      fall_len <= 0;
    end else begin
      if (live != 2'h3) begin
        live <= live + 2'h1;
      end
      if (cells_out.fall_mono.true_output) begin
        fall_len <= fall_len + 1;
      end else begin
        fall_len <= 0;
      end
    end
  end

  // ------
  // Monoflop start sequences
  // ------
  sequence rise_when_idle;
    live == 2'h3 && $rose(cells_in.rise_trigger)
      ##2 !cells_out.rise_mono.true_output;
  endsequence
  sequence fall_when_idle;
    live == 2'h3 && $fell(cells_in.fall_trigger)
      ##2 !cells_out.fall_mono.true_output;
  endsequence

  // ------
  // Assertions; those from input to output allow three edges
  // ------
  a_latch_follow: assert property (
    cells_in.latch_strobe |-> ##3
      cells_out.latch.true_output == $past(cells_in.latch_data, 3))
    else $error("latch does not follow data");
  a_latch_hold: assert property (
    !cells_in.latch_strobe |-> ##3 $stable(cells_out.latch))
    else $error("latch changed with strobe low");
  a_dff_capture: assert property (
    live == 2'h3 && $rose(cells_in.dff_strobe) |-> ##3
      cells_out.dff.true_output == $past(cells_in.dff_data, 3))
    else $error("data cell missed its capture");
  a_dff_hold: assert property (
    live == 2'h3 && !$rose(cells_in.dff_strobe) |-> ##3
      $stable(cells_out.dff))
    else $error("data cell changed without edge");
  a_dffc_clear: assert property (
    cells_in.dffc_force_low |-> ##3 cells_out.dffc == PAIR_CLEAR)
    else $error("clear did not win");
  a_dffsc_force: assert property (
    !cells_in.dffsc_force_low_n || cells_in.dffsc_force_high |-> ##3
      cells_out.dffsc == {$past(cells_in.dffsc_force_high, 3),
                          !$past(cells_in.dffsc_force_low_n, 3)})
    else $error("set and clear cell wrong under force");
  a_dffn_force: assert property (
    !cells_in.dffn_force_high_n || !cells_in.dffn_force_low_n |-> ##3
      cells_out.dffn == {!$past(cells_in.dffn_force_high_n, 3),
                         !$past(cells_in.dffn_force_low_n, 3)})
    else $error("low force cell wrong under force");
  a_tff_toggle: assert property (
    live == 2'h3 && $rose(cells_in.tff_toggle) |-> ##3
      cells_out.tff.true_output != $past(cells_out.tff.true_output))
    else $error("toggle cell did not swap");
  a_toggle_pairs: assert property (
    cells_out.tff.true_output != cells_out.tff.complement_output)
    else $error("toggle outputs not complementary");
  a_tffr_clear: assert property (
    cells_in.tffr_force_low |-> ##3 cells_out.tffr == PAIR_CLEAR)
    else $error("toggle clear did not win");
  a_tffrn_clear: assert property (
    !cells_in.tffrn_force_low_n |-> ##3 cells_out.tffrn == PAIR_CLEAR)
    else $error("inverted toggle clear did not win");
  a_tffsn_set: assert property (
    !cells_in.tffsn_force_high_n |-> ##3 cells_out.tffsn == PAIR_SET)
    else $error("inverted toggle set did not win");
  a_rise_start: assert property (
    rise_when_idle |-> ##1 cells_out.rise_mono.true_output)
    else $error("rising monoflop did not start");
  a_fall_start: assert property (
    fall_when_idle |-> ##1 cells_out.fall_mono.true_output)
    else $error("falling monoflop did not start");
  a_rise_restart: assert property (
    RISE_RETRIGGER && live == 2'h3 && $rose(cells_in.rise_trigger)
      |-> ##3 cells_out.rise_mono.true_output)
    else $error("retrigger edge gave no pulse");
  a_fall_width: assert property (
    !FALL_RETRIGGER && live == 2'h3
      && $fell(cells_out.fall_mono.true_output) |->
      fall_len == FALL_CYCLES)
    else $error("falling pulse width wrong");
  a_mono_pairs: assert property (
    cells_out.rise_mono.true_output != cells_out.rise_mono.complement_output
    && cells_out.fall_mono.true_output
      != cells_out.fall_mono.complement_output)
    else $error("monoflop outputs not complementary");
  a_data_pairs: assert property (
    cells_out.dff.true_output != cells_out.dff.complement_output
    && cells_out.dffc.true_output != cells_out.dffc.complement_output)
    else $error("data outputs not complementary");
endmodule

bind flip_flop_cell_set flip_flop_cell_checker #(
  .RISE_PULSE_TIME_US(RISE_PULSE_TIME_US),
  .FALL_PULSE_TIME_US(FALL_PULSE_TIME_US),
  .RISE_RETRIGGER(RISE_RETRIGGER),
  .FALL_RETRIGGER(FALL_RETRIGGER)
) checker_inst (
  .clock(clock),
  .rst_n(rst_n),
  .cells_in(cells_in),
  .cells_out(cells_out)
);

// ==== neighbour_cells.sv ====
`timescale 1ns/1ps
// ------
// Neighbour logic feeding the cell inputs
// ------
module neighbour_cells (
  input wire logic clock,
  input flip_flop_cell_pkg::cell_in_type request,
  output flip_flop_cell_pkg::cell_in_type cells_in
);
  import flip_flop_cell_pkg::*;
  // All zeros, active-low forces asserted, until the first falling edge
  initial cells_in = '0;
  // Changes only on falling edges, far from the sampling edge
  always @(negedge clock) begin
    cells_in <= request;
  end
endmodule

// ==== tb_flip_flop_cell_set.sv ====
`timescale 1ns/1ps
module tb_flip_flop_cell_set;
  import flip_flop_cell_pkg::*;
  localparam int CYCLES = 1 * CLOCK_MHZ; // Pulse of 1 us
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  cell_in_type request; // Wanted input levels
  cell_in_type cells_in;
  cell_out_type cells_out;
  int fails = 0;
  int samples_checked = 0;
  int len;

  always #2 clock = ~clock;

  neighbour_cells partner (.clock(clock), .request(request),
    .cells_in(cells_in));
  flip_flop_cell_set #(.RISE_PULSE_TIME_US(1), .FALL_PULSE_TIME_US(1),
    .RISE_RETRIGGER(1'b1), .FALL_RETRIGGER(1'b0)) DUT (.clock(clock),
    .rst_n(rst_n), .cells_in(cells_in), .cells_out(cells_out));

  // ------
  // Shared tasks
  // ------
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check_pair(input pair_type got, input pair_type exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_len(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Four cycles: covers the three-edge latency plus the drive edge
  task automatic go();
    repeat (4) @(negedge clock);
    #1;
  endtask
  // Counts further high cycles of one monoflop, bounded
  task automatic count_high(input logic rise, output int n);
    n = 0;
    while (n < 2000) begin
      @(negedge clock);
      if ((rise ? cells_out.rise_mono.true_output
          : cells_out.fall_mono.true_output) !== 1'b1) begin
        break;
      end
      n++;
    end
    if (n == 2000) begin
      fails++;
      final_report();
    end
  endtask

  // ------
  // Scenarios
  // ------
  task automatic test_latch();
    request.latch_data = 1'b1;
    request.latch_strobe = 1'b1;
    go();
    check_pair(cells_out.latch, PAIR_SET);
    request.latch_data = 1'b0;
    go();
    check_pair(cells_out.latch, PAIR_CLEAR);
    request.latch_strobe = 1'b0;
    go();
    request.latch_data = 1'b1;
    go();
    check_pair(cells_out.latch, PAIR_CLEAR);
    $display("latch test ended");
  endtask
  task automatic test_dff();
    request.dff_data = 1'b1;
    go();
    check_pair(cells_out.dff, PAIR_CLEAR);
    request.dff_strobe = 1'b1;
    go();
    check_pair(cells_out.dff, PAIR_SET);
    request.dff_data = 1'b0;
    go();
    check_pair(cells_out.dff, PAIR_SET);
    request.dff_strobe = 1'b0;
    go();
    request.dff_strobe = 1'b1;
    go();
    check_pair(cells_out.dff, PAIR_CLEAR);
    request.dffc_data = 1'b1;
    request.dffc_strobe = 1'b1;
    go();
    check_pair(cells_out.dffc, PAIR_SET);
    request.dffc_force_low = 1'b1;
    request.dffc_strobe = 1'b0;
    go();
    request.dffc_strobe = 1'b1;
    go();
    check_pair(cells_out.dffc, PAIR_CLEAR);
    request.dffc_force_low = 1'b0;
    go();
    check_pair(cells_out.dffc, PAIR_CLEAR);
    $display("data cell test ended");
  endtask
  task automatic test_forces();
    request.dffsc_force_low_n = 1'b0;
    request.dffn_force_high_n = 1'b0;
    go();
    check_pair(cells_out.dffsc, PAIR_CLEAR);
    check_pair(cells_out.dffn, PAIR_SET);
    request.dffsc_force_low_n = 1'b1;
    request.dffsc_force_high = 1'b1;
    request.dffn_force_high_n = 1'b1;
    request.dffn_force_low_n = 1'b0;
    go();
    check_pair(cells_out.dffsc, PAIR_SET);
    check_pair(cells_out.dffn, PAIR_CLEAR);
    request.dffsc_force_low_n = 1'b0;
    request.dffn_force_high_n = 1'b0;
    go();
    check_pair(cells_out.dffsc, PAIR_BOTH);
    check_pair(cells_out.dffn, PAIR_BOTH);
    request.dffsc_force_low_n = 1'b1;
    request.dffsc_force_high = 1'b0;
    request.dffn_force_high_n = 1'b1;
    request.dffn_force_low_n = 1'b1;
    go();
    check_pair(cells_out.dffsc, PAIR_SET);
    check_pair(cells_out.dffn, PAIR_SET);
    request.dffsc_strobe = 1'b1;
    request.dffn_strobe = 1'b1;
    go();
    check_pair(cells_out.dffsc, PAIR_CLEAR);
    check_pair(cells_out.dffn, PAIR_CLEAR);
    $display("force test ended");
  endtask
  task automatic test_toggles();
    for (int i = 0; i < 4; i++) begin
      request.tff_toggle = 1'b1;
      go();
      check_pair(cells_out.tff, i % 2 == 0 ? PAIR_SET : PAIR_CLEAR);
      request.tff_toggle = 1'b0;
      go();
      check_pair(cells_out.tff, i % 2 == 0 ? PAIR_SET : PAIR_CLEAR);
    end
    request.tffr_force_low = 1'b1;
    request.tffr_toggle = 1'b1;
    request.tffrn_toggle = 1'b1;
    request.tffsn_force_high_n = 1'b0;
    go();
    check_pair(cells_out.tffr, PAIR_CLEAR);
    check_pair(cells_out.tffrn, PAIR_SET);
    check_pair(cells_out.tffsn, PAIR_SET);
    request.tffr_force_low = 1'b0;
    request.tffr_toggle = 1'b0;
    request.tffrn_force_low_n = 1'b0;
    request.tffsn_force_high_n = 1'b1;
    go();
    request.tffr_toggle = 1'b1;
    request.tffsn_toggle = 1'b1;
    go();
    check_pair(cells_out.tffr, PAIR_SET);
    check_pair(cells_out.tffrn, PAIR_CLEAR);
    check_pair(cells_out.tffsn, PAIR_CLEAR);
    $display("toggle test ended");
  endtask
  task automatic test_monos();
    request.rise_trigger = 1'b1;
    request.fall_trigger = 1'b1;
    go();
    check_pair(cells_out.rise_mono, PAIR_SET);
    check_pair(cells_out.fall_mono, PAIR_CLEAR);
    count_high(1'b1, len);
    check_len(len, CYCLES - 1);
    check_pair(cells_out.rise_mono, PAIR_CLEAR);
    request.rise_trigger = 1'b0;
    request.fall_trigger = 1'b0;
    go();
    check_pair(cells_out.fall_mono, PAIR_SET);
    request.rise_trigger = 1'b1;
    request.fall_trigger = 1'b1;
    go();
    request.rise_trigger = 1'b0;
    request.fall_trigger = 1'b0;
    go();
    request.rise_trigger = 1'b1;
    count_high(1'b1, len);
    check_len(len, CYCLES + 3);
    check_pair(cells_out.fall_mono, PAIR_CLEAR);
    $display("monoflop test ended");
  endtask

  initial begin
    request = '0;
    request.dffsc_force_low_n = 1'b1;
    request.dffn_force_high_n = 1'b1;
    request.dffn_force_low_n = 1'b1;
    request.tffrn_force_low_n = 1'b1;
    request.tffsn_force_high_n = 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    go();
    test_latch();
    test_dff();
    test_forces();
    test_toggles();
    test_monos();
    final_report();
  end
endmodule
